/* core/supply_monitor_defines.vh */
// Constants for the auxiliary supply monitor readout block.
// Assumes a single 20 MHz system clock and a synchronous active-low reset.
// Contract
// - Alarm high while supply outside thresholds
// - Busy high for each whole conversion
// - Channel code presented when busy falls
// - Channel 02h result lands at index 02h
// - Strobe captures index, drives register contents
// - End-of-sequence pulses one cycle per pass
// - Strobe from end-of-sequence yields result, valid flag
// - Conversion takes 26 converter clock cycles
// - Without port clock, alarm continues, no readout
`ifndef SUPPLY_MONITOR_DEFINES_VH
`define SUPPLY_MONITOR_DEFINES_VH

`define AUX_SUPPLY_RESULT_IDX 7'h02
`define CAL_CHANNEL 5'h08
`define AUX_CHANNEL 5'h02
`define CONV_CYCLES 5'h1A
`define CLK_DIV_RESET 8'h0A
`define CLK_DIV_MIN 8'h02
`define UPPER_THRESH_RESET 16'hE000
`define LOWER_THRESH_RESET 16'hCAAA
`define AVG_SHIFT 4
`define AVG_COUNT 5'h10
`define PORT_CLK_TIMEOUT 8'h10

`endif

/* core/sync3.v */
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module sync3 (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire async_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Only the second and third stages are compared; the first may be metastable
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

/* core/supply_monitor_result_readout.v */
// Digital side of the auxiliary supply monitor: sequencer, averaging, alarm
// and a read-only register port. Assumes the converter's raw sample arrives
// on sample_i and is taken at the end of each conversion, and that the port
// clock is sampled on sys_clk_i only to detect its presence. Reads are refused
// while the port clock is absent; conversions and the alarm keep running.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defines.vh"
module supply_monitor_result_readout (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire port_clock_i,
  input wire [7:0] clk_div_i,
  input wire [15:0] upper_thresh_i,
  input wire [15:0] lower_thresh_i,
  input wire [15:0] sample_i,
  input wire port_access_strobe_i,
  input wire port_write_strobe_i,
  input wire [6:0] port_register_index_i,
  output reg [15:0] read_data_o,
  output reg read_valid_flag_o,
  output reg busy_o,
  output reg [4:0] channel_o,
  output reg end_of_sequence_o,
  output reg aux_alarm_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  wire port_clk_lvl;
  reg port_clk_prev_q;
  reg [7:0] clk_gap_q;
  reg port_clk_present_q;
  reg [7:0] div_cnt_q;
  reg conv_tick;
  reg [4:0] conv_cnt_q;
  reg state_q;
  reg [4:0] cur_chan_q;
  reg [19:0] acc_q;
  reg [4:0] avg_cnt_q;
  reg [15:0] aux_supply_result_q;
  reg [15:0] cal_result_q;
  reg read_pend_q;
  reg [6:0] idx_q;
  wire [7:0] div_eff;
  wire [19:0] acc_next;
  wire [19:0] avg_full;

  // Pin samples pass the three-stage filter
  sync3 u_port_clk_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(port_clock_i),
    .level_o(port_clk_lvl)
  );

  // Outside-window test shared by alarm path
  function outside;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      outside = (v > hi) || (v < lo);
    end
  endfunction

  // Register map decode: index 02h holds the averaged auxiliary result,
  // 08h the last calibration sample, everything else reads zero
  function [15:0] map_read;
    input [6:0] idx;
    input [15:0] aux;
    input [15:0] cal;
    begin
      if (idx == `AUX_SUPPLY_RESULT_IDX) begin
        map_read = aux;
      end else if (idx == {2'b00, `CAL_CHANNEL}) begin
        map_read = cal;
      end else begin
        map_read = 16'h0000;
      end
    end
  endfunction

  // Divider of one would tick the converter every cycle and zero only every 256; clamp both to two
  assign div_eff = (clk_div_i < `CLK_DIV_MIN) ? `CLK_DIV_MIN : clk_div_i;

  // Running window sum including the sample now arriving; sixteen 16-bit
  // samples fit in 20 bits, so the sum never wraps
  assign acc_next = acc_q + {4'h0, sample_i};

  // Dividing by the window length leaves the top four bits zero, so the
  // low 16 bits carry the whole average
  assign avg_full = acc_next >> `AVG_SHIFT;

  // Port clock presence: any filtered level change within the timeout window.
  // Limitation: the pin is sampled on the system clock, so a port clock whose
  // sampled pattern flips every cycle never passes the agreement filter and
  // reads as absent; the port clock must beat slowly against sys_clk_i, with
  // half of that beat period shorter than the timeout.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      port_clk_prev_q <= 1'b0;
      clk_gap_q <= 8'h00;
      port_clk_present_q <= 1'b0;
    end else begin
      port_clk_prev_q <= port_clk_lvl;
      if (port_clk_lvl != port_clk_prev_q) begin
        clk_gap_q <= 8'h00;
        port_clk_present_q <= 1'b1;
      end else if (clk_gap_q == `PORT_CLK_TIMEOUT) begin
        port_clk_present_q <= 1'b0;
      end else begin
        clk_gap_q <= clk_gap_q + 8'h01;
      end
    end
  end

  // Converter clock: runs from the local clock so monitoring never stops.
  // A tick every div_eff system cycles stands in for the converter clock.
  always @* begin
    conv_tick = (div_cnt_q == div_eff - 8'h01);
  end

  // Divider counter wraps on each tick
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      div_cnt_q <= 8'h00;
    end else if (conv_tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Sequencer: calibration channel then auxiliary supply, 26 ticks each.
  // Busy rises on a tick, falls on the 26th tick after it and stays low for
  // one tick before the next conversion, so it pulses once per conversion.
  // channel_o and end_of_sequence_o move on the same edge as the busy fall.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= 5'h00;
      cur_chan_q <= `CAL_CHANNEL;
      busy_o <= 1'b0;
      channel_o <= 5'h00;
      end_of_sequence_o <= 1'b0;
      acc_q <= 20'h00000;
      avg_cnt_q <= 5'h00;
      aux_supply_result_q <= 16'h0000;
      cal_result_q <= 16'h0000;
      aux_alarm_o <= 1'b0;
    end else begin
      end_of_sequence_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (conv_tick) begin
            state_q <= ST_CONV;
            busy_o <= 1'b1;
            conv_cnt_q <= 5'h00;
          end
        end
        ST_CONV: begin
          if (conv_tick) begin
            if (conv_cnt_q == `CONV_CYCLES - 5'h01) begin
              busy_o <= 1'b0;
              channel_o <= cur_chan_q;
              state_q <= ST_IDLE;
              if (cur_chan_q == `CAL_CHANNEL) begin
                cal_result_q <= sample_i;
                cur_chan_q <= `AUX_CHANNEL;
              end else begin
                cur_chan_q <= `CAL_CHANNEL;
                end_of_sequence_o <= 1'b1;
                if (avg_cnt_q == `AVG_COUNT - 5'h01) begin
                  // Result slot for channel 02h sits at index 02h
                  aux_supply_result_q <= avg_full[15:0];
                  // Alarm judges the same average that the port will show
                  aux_alarm_o <= outside(avg_full[15:0], lower_thresh_i, upper_thresh_i);
                  acc_q <= 20'h00000;
                  avg_cnt_q <= 5'h00;
                end else begin
                  acc_q <= acc_next;
                  avg_cnt_q <= avg_cnt_q + 5'h01;
                end
              end
            end else begin
              conv_cnt_q <= conv_cnt_q + 5'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Register port: strobe latches index, data follows one cycle later.
  // Timing: strobe sampled on edge n, index held in idx_q, data and the
  // one-cycle valid flag appear after edge n+1. Back-to-back strobes each
  // get their own answer because the pending bit is rebuilt every cycle.
  // Writes are ignored; the map is read only
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      read_pend_q <= 1'b0;
      idx_q <= 7'h00;
      read_data_o <= 16'h0000;
      read_valid_flag_o <= 1'b0;
    end else begin
      read_valid_flag_o <= 1'b0;
      read_pend_q <= 1'b0;
      if (port_access_strobe_i && !port_write_strobe_i && port_clk_present_q) begin
        idx_q <= port_register_index_i;
        read_pend_q <= 1'b1;
      end
      // Data holds between reads so capture logic sees a settled bus
      if (read_pend_q) begin
        read_valid_flag_o <= 1'b1;
        read_data_o <= map_read(idx_q, aux_supply_result_q, cal_result_q);
      end
    end
  end
endmodule
`default_nettype wire

/* test/supply_monitor_result_readout_chk.sv */
// Checker for the monitor's sequencer outputs and register read port.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defines.vh"
module supply_monitor_chk (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] clk_div_i,
  input wire logic port_access_strobe_i,
  input wire logic port_write_strobe_i,
  input wire logic [6:0] port_register_index_i,
  input wire logic [15:0] read_data_o,
  input wire logic read_valid_flag_o,
  input wire logic busy_o,
  input wire logic [4:0] channel_o,
  input wire logic end_of_sequence_o
);
  logic [12:0] bcnt_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Busy stretch length, kept in a counter since it is far above a repeat count
  always_ff @(posedge sys_clk_i) bcnt_q <= (!rst_b_i || !busy_o) ? 13'h0000 : bcnt_q + 13'h0001;
  AST_BUSY_LEN: assert property ($fell(busy_o) |-> bcnt_q == 13'h001A * clk_div_i)
    else $error("busy width wrong");
  AST_CHAN_FALL: assert property ($changed(channel_o) |-> $fell(busy_o))
    else $error("channel moved off busy fall");
  AST_EOS_ONE: assert property (end_of_sequence_o |=> !end_of_sequence_o)
    else $error("sequence end too long");
  AST_EOS_AUX: assert property (end_of_sequence_o |-> channel_o == `AUX_CHANNEL)
    else $error("sequence end not after aux");
  AST_VALID_CAUSE: assert property (read_valid_flag_o |-> $past(port_access_strobe_i, 2))
    else $error("valid without strobe");
  AST_WR_REFUSED: assert property (read_valid_flag_o |-> !$past(port_write_strobe_i, 2))
    else $error("write answered");
  AST_DATA_HOLD: assert property (!read_valid_flag_o |-> $stable(read_data_o))
    else $error("read data moved");
  AST_OTHER_ZERO: assert property (read_valid_flag_o && $past(port_register_index_i, 2) != 7'h02
    && $past(port_register_index_i, 2) != 7'h08 |-> read_data_o == 16'h0000)
    else $error("unmapped index not zero");
endmodule
bind supply_monitor_result_readout supply_monitor_chk i_supply_monitor_chk (.sys_clk_i, .rst_b_i,
  .clk_div_i, .port_access_strobe_i, .port_write_strobe_i, .port_register_index_i, .read_data_o,
  .read_valid_flag_o, .busy_o, .channel_o, .end_of_sequence_o);
`default_nettype wire

/* test/supply_monitor_user_side.sv */
// Logic outside the monitor: port clock, and the read wiring from the outputs.
// Assumes the bench picks auto wiring or its own strobes.
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_user_side (
  input wire logic pclk_en_i,
  input wire logic auto_i,
  input wire logic eos_i,
  input wire logic [4:0] ch_i,
  input wire logic stb_i,
  input wire logic wr_i,
  input wire logic [6:0] idx_i,
  output var logic port_clock_o,
  output logic strobe_o,
  output logic write_o,
  output logic [6:0] index_o
);
  initial port_clock_o = 1'b0;
  // About 41.7 MHz: against the 20 MHz system clock it beats slowly, so the
  // sampled level holds six cycles at a time. Stands still when absent.
  always #12 if (pclk_en_i) port_clock_o = ~port_clock_o;
  // Channel code doubles as index, sequence end as strobe
  assign strobe_o = auto_i ? eos_i : stb_i;
  assign index_o = auto_i ? {2'b00, ch_i} : idx_i;
  assign write_o = auto_i ? 1'b0 : wr_i;
endmodule
`default_nettype wire

/* test/supply_monitor_result_readout_tb_top.sv */
// Bench: supply levels, alarm, random reads, refused reads.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defines.vh"
module supply_monitor_result_readout_tb_top;
  logic clk = 0, rst_b = 0, pen = 1, auto = 1, stb = 0, wr = 0, a_stb, a_wr, pclk, rv, bsy, eos, alm;
  logic [6:0] idx = 0, a_idx;
  logic [4:0] ch;
  logic [15:0] smp = 16'h0000, rd, val, r = 16'hC559;
  int err_count = 0, n_checks = 0, i;
  always #25 clk = ~clk;
  supply_monitor_user_side i_supply_monitor_user_side (.pclk_en_i(pen), .auto_i(auto), .eos_i(eos),
    .ch_i(ch), .stb_i(stb), .wr_i(wr), .idx_i(idx), .port_clock_o(pclk), .strobe_o(a_stb),
    .write_o(a_wr), .index_o(a_idx));
  supply_monitor_result_readout i_supply_monitor_result_readout (.sys_clk_i(clk), .rst_b_i(rst_b),
    .port_clock_i(pclk), .clk_div_i(8'h02), .upper_thresh_i(`UPPER_THRESH_RESET),
    .lower_thresh_i(`LOWER_THRESH_RESET), .sample_i(smp), .port_access_strobe_i(a_stb),
    .port_write_strobe_i(a_wr), .port_register_index_i(a_idx), .read_data_o(rd),
    .read_valid_flag_o(rv), .busy_o(bsy), .channel_o(ch), .end_of_sequence_o(eos), .aux_alarm_o(alm));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Wait for the valid pulse, bounded since refusals never bring one
  task wv;
    i = 0;
    while (rv !== 1'b1 && i < 6) begin
      @(negedge clk);
      i++;
    end
  endtask
  task rdx(input logic [6:0] a, input logic w);
    @(posedge clk);
    stb <= 1'b1;
    idx <= a;
    wr <= w;
    @(posedge clk);
    stb <= 1'b0;
    wr <= 1'b0;
    wv;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    // Random level, above upper, at lower bound, just below lower
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      val = k == 0 ? r : k == 1 ? 16'hE001 : k == 2 ? `LOWER_THRESH_RESET : 16'hCAA9;
      @(posedge clk);
      smp <= val;
      repeat (34) begin
        @(negedge clk);
        while (eos !== 1'b1) @(negedge clk);
      end
      wv;
      chk("aux", val, rd);
      chk("alarm", {15'h0000, val > `UPPER_THRESH_RESET || val < `LOWER_THRESH_RESET}, {15'h0000, alm});
      // Capture as an acquisition system would, on the next busy rise
      @(posedge bsy);
      chk("busy_capture", val, rd);
    end
    auto <= 1'b0;
    // Corner indexes first, then random ones; cal reads the same held sample
    for (int k = 0; k < 10; k++) begin
      r = lfsr(r);
      if (k < 3) r[6:0] = k == 0 ? 7'h02 : k == 1 ? 7'h08 : 7'h7F;
      rdx(r[6:0], 1'b0);
      chk("read", (r[6:0] == 7'h02 || r[6:0] == 7'h08) ? val : 16'h0000, rd);
    end
    rdx(7'h02, 1'b1);
    chk("write", 16'h0000, {15'h0000, rv});
    pen <= 1'b0;
    repeat (40) @(posedge clk);
    rdx(7'h02, 1'b0);
    chk("noclk", 16'h0000, {15'h0000, rv});
    stop_test;
  end
  initial begin
    #(50 * 30000);
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
